//--- src/tsr_pkg.sv
// Package for the touch scan readout register block.
// Assumes a byte-wide register port decoded by an upstream I2C slave.
package tsr_pkg;
  localparam logic [7:0] ADDR_LOCK_OFS = 8'h79;
  localparam logic [7:0] INPUT_EN_OFS = 8'h07;
  localparam logic [7:0] SLAVE_ADDR_OFS = 8'h7C;
  localparam logic [7:0] BUTTON_SEL_OFS = 8'h81;
  localparam logic [7:0] BASE_HI_OFS = 8'h82;
  localparam logic [7:0] BASE_LO_OFS = 8'h83;
  localparam logic [7:0] DELTA_HI_OFS = 8'h84;
  localparam logic [7:0] DELTA_LO_OFS = 8'h85;
  localparam logic [7:0] RAW_HI_OFS = 8'h86;
  localparam logic [7:0] RAW_LO_OFS = 8'h87;
  localparam logic [7:0] TOUCH_OFS = 8'h88;
  localparam logic [7:0] UNLOCK_B0 = 8'h3C;
  localparam logic [7:0] UNLOCK_B1 = 8'hA5;
  localparam logic [7:0] UNLOCK_B2 = 8'h69;
  localparam logic [7:0] LOCK_B0 = 8'h96;
  localparam logic [7:0] LOCK_B1 = 8'h5A;
  localparam logic [7:0] LOCK_B2 = 8'hC3;
  localparam logic [7:0] SLAVE_ADDR_RST = 8'h00;
  localparam logic [7:0] BUTTON_SEL_RST = 8'h00;
  localparam int PULLUP_BIT = 7;
  localparam int READ_EN_BIT = 7;
  localparam int NUM_BUTTONS = 2;
  typedef enum logic [3:0] {
    TSR_SEQ_IDLE = 4'h1,
    TSR_SEQ_ONE = 4'h2,
    TSR_SEQ_TWO = 4'h4,
    TSR_SEQ_DONE = 4'h8
  } tsr_seq_t;
endpackage

//--- src/tsr_key_seq.sv
// Three-byte key sequence detector for the address lock register.
// Assumes one write strobe per byte on the system clock.
`timescale 1ns/1ps
`default_nettype none
module tsr_key_seq #(
  parameter logic [7:0] KEY0 = 8'h00,
  parameter logic [7:0] KEY1 = 8'h00,
  parameter logic [7:0] KEY2 = 8'h00
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wrByte,
  input wire logic [7:0] wrData,
  output logic matched
);
  tsr_pkg::tsr_seq_t state;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= tsr_pkg::TSR_SEQ_IDLE;
    end else if (wrByte) begin
      case (state)
        tsr_pkg::TSR_SEQ_IDLE:
          state <= (wrData == KEY0) ? tsr_pkg::TSR_SEQ_ONE : tsr_pkg::TSR_SEQ_IDLE;
        tsr_pkg::TSR_SEQ_ONE:
          state <= (wrData == KEY1) ? tsr_pkg::TSR_SEQ_TWO :
                   (wrData == KEY0) ? tsr_pkg::TSR_SEQ_ONE : tsr_pkg::TSR_SEQ_IDLE;
        tsr_pkg::TSR_SEQ_TWO:
          state <= (wrData == KEY2) ? tsr_pkg::TSR_SEQ_DONE :
                   (wrData == KEY0) ? tsr_pkg::TSR_SEQ_ONE : tsr_pkg::TSR_SEQ_IDLE;
        default:
          state <= (wrData == KEY0) ? tsr_pkg::TSR_SEQ_ONE : tsr_pkg::TSR_SEQ_IDLE;
      endcase
    end else if (state == tsr_pkg::TSR_SEQ_DONE) begin
      state <= tsr_pkg::TSR_SEQ_IDLE;
    end
  end
  // One-cycle pulse after the third key byte
  assign matched = (state == tsr_pkg::TSR_SEQ_DONE);
endmodule
`default_nettype wire

//--- src/touch_scan_readout_regs.sv
// Register file for touch scan readout, slave address and button selection.
// Assumes an upstream I2C slave gives byte reads and writes on clk_sys, and
// the sensing engine supplies per-button counts and touch state synchronously.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - New address applied only on relock
// - Address bit 7 disables pull-ups
// - Address bits 6:0 are slave address
// - Results exposed for one selected input
// - Only enabled sensing pins may be selected
// - Select bit 7 gates result readout
// - Select mask must be one-hot, or zero from reset
// - Baseline read as high, low bytes
// - Delta count read as high, low bytes
// - Raw count read as high, low bytes
// - Touch state one bit per button
module touch_scan_readout_regs (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  output logic regRdValid,
  input wire logic [1:0] inputEnable,
  input wire logic [31:0] baselineValue,
  input wire logic [31:0] deltaValue,
  input wire logic [31:0] rawValue,
  input wire logic [1:0] perButtonTouch,
  output logic [6:0] activeSlaveAddress,
  output logic pullupDisable,
  output logic [1:0] buttonOnehotMask,
  output logic readEnable,
  output logic addressLockState
);
  logic [7:0] pendingAddr;
  logic [7:0] buttonSel;
  logic unlockHit;
  logic lockHit;
  logic lockWrite;
  logic selIdx;
  logic [15:0] selBase;
  logic [15:0] selDelta;
  logic [15:0] selRaw;
  logic [7:0] next_rdData;
  logic [1:0] wrMask;

  assign lockWrite = regWrite && (regAddr == tsr_pkg::ADDR_LOCK_OFS);
  assign wrMask = regWrData[1:0];

  tsr_key_seq #(
    .KEY0(tsr_pkg::UNLOCK_B0),
    .KEY1(tsr_pkg::UNLOCK_B1),
    .KEY2(tsr_pkg::UNLOCK_B2)
  ) u_unlock (
    .clk_sys(clk_sys),
    .rst(rst),
    .wrByte(lockWrite),
    .wrData(regWrData),
    .matched(unlockHit)
  );

  tsr_key_seq #(
    .KEY0(tsr_pkg::LOCK_B0),
    .KEY1(tsr_pkg::LOCK_B1),
    .KEY2(tsr_pkg::LOCK_B2)
  ) u_lock (
    .clk_sys(clk_sys),
    .rst(rst),
    .wrByte(lockWrite),
    .wrData(regWrData),
    .matched(lockHit)
  );

  // Locked out of reset so the address cannot be changed by accident
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      addressLockState <= 1'b1;
    end else if (lockHit) begin
      addressLockState <= 1'b1;
    end else if (unlockHit) begin
      addressLockState <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pendingAddr <= tsr_pkg::SLAVE_ADDR_RST;
    end else if (regWrite && regAddr == tsr_pkg::SLAVE_ADDR_OFS && !addressLockState) begin
      pendingAddr <= regWrData;
    end
  end

  // Applied copy only moves on a relock, so a half-written address never goes live
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pullupDisable <= tsr_pkg::SLAVE_ADDR_RST[tsr_pkg::PULLUP_BIT];
      activeSlaveAddress <= tsr_pkg::SLAVE_ADDR_RST[6:0];
    end else if (lockHit && !addressLockState) begin
      pullupDisable <= pendingAddr[tsr_pkg::PULLUP_BIT];
      activeSlaveAddress <= pendingAddr[6:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      buttonSel <= tsr_pkg::BUTTON_SEL_RST;
    end else if (regWrite && regAddr == tsr_pkg::BUTTON_SEL_OFS) begin
      buttonSel[tsr_pkg::READ_EN_BIT] <= regWrData[tsr_pkg::READ_EN_BIT];
      if ((wrMask == 2'h1 || wrMask == 2'h2) && ((wrMask & inputEnable) != 2'h0)) begin
        buttonSel[1:0] <= wrMask;
      end
    end
  end

  assign buttonOnehotMask = buttonSel[1:0];
  assign readEnable = buttonSel[tsr_pkg::READ_EN_BIT];
  assign selIdx = buttonSel[1];

  // Counts of the one selected input only
  always_comb begin
    selBase = selIdx ? baselineValue[31:16] : baselineValue[15:0];
    selDelta = selIdx ? deltaValue[31:16] : deltaValue[15:0];
    selRaw = selIdx ? rawValue[31:16] : rawValue[15:0];
  end

  always_comb begin
    next_rdData = 8'h00;
    case (regAddr)
      tsr_pkg::ADDR_LOCK_OFS: next_rdData = {7'h00, addressLockState};
      tsr_pkg::SLAVE_ADDR_OFS: next_rdData = pendingAddr;
      tsr_pkg::BUTTON_SEL_OFS: next_rdData = buttonSel;
      tsr_pkg::BASE_HI_OFS: next_rdData = readEnable ? selBase[15:8] : 8'h00;
      tsr_pkg::BASE_LO_OFS: next_rdData = readEnable ? selBase[7:0] : 8'h00;
      tsr_pkg::DELTA_HI_OFS: next_rdData = readEnable ? selDelta[15:8] : 8'h00;
      tsr_pkg::DELTA_LO_OFS: next_rdData = readEnable ? selDelta[7:0] : 8'h00;
      tsr_pkg::RAW_HI_OFS: next_rdData = readEnable ? selRaw[15:8] : 8'h00;
      tsr_pkg::RAW_LO_OFS: next_rdData = readEnable ? selRaw[7:0] : 8'h00;
      tsr_pkg::TOUCH_OFS: next_rdData = {6'h00, perButtonTouch};
      default: next_rdData = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      regRdData <= 8'h00;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRead;
      if (regRead) begin
        regRdData <= next_rdData;
      end
    end
  end

  // Key bytes one idle cycle apart, so no stray lock write can restart it
  sequence s_unlockKey;
    (lockWrite && regWrData == tsr_pkg::UNLOCK_B0) ##1 !lockWrite
    ##1 (lockWrite && regWrData == tsr_pkg::UNLOCK_B1) ##1 !lockWrite
    ##1 (lockWrite && regWrData == tsr_pkg::UNLOCK_B2);
  endsequence

  property p_lockedIgnore;
    @(posedge clk_sys) disable iff (rst)
      (regWrite && regAddr == tsr_pkg::SLAVE_ADDR_OFS && addressLockState)
      |=> $stable(pendingAddr);
  endproperty
  a_lockedIgnore: assert property (p_lockedIgnore) else $error("write taken while locked");

  property p_applyOnLock;
    @(posedge clk_sys) disable iff (rst)
      !$past(lockHit) |-> $stable(activeSlaveAddress) && $stable(pullupDisable);
  endproperty
  a_applyOnLock: assert property (p_applyOnLock) else $error("address moved without relock");

  property p_applyValue;
    @(posedge clk_sys) disable iff (rst)
      (lockHit && !addressLockState) |=>
        activeSlaveAddress == $past(pendingAddr[6:0]) && pullupDisable == $past(pendingAddr[7]);
  endproperty
  a_applyValue: assert property (p_applyValue) else $error("relock applied wrong value");

  property p_oneHot;
    @(posedge clk_sys) disable iff (rst)
      buttonOnehotMask == 2'h0 || $onehot(buttonOnehotMask);
  endproperty
  a_oneHot: assert property (p_oneHot) else $error("selection not one-hot");

  property p_enabledOnly;
    @(posedge clk_sys) disable iff (rst)
      (regWrite && regAddr == tsr_pkg::BUTTON_SEL_OFS && (wrMask & inputEnable) == 2'h0)
      |=> $stable(buttonOnehotMask);
  endproperty
  a_enabledOnly: assert property (p_enabledOnly) else $error("disabled pin selected");

  property p_readGate;
    @(posedge clk_sys) disable iff (rst)
      (regRead && !readEnable && regAddr >= tsr_pkg::BASE_HI_OFS && regAddr <= tsr_pkg::RAW_LO_OFS)
      |=> regRdValid && regRdData == 8'h00;
  endproperty
  a_readGate: assert property (p_readGate) else $error("readout not gated");

  property p_touchRead;
    @(posedge clk_sys) disable iff (rst)
      (regRead && regAddr == tsr_pkg::TOUCH_OFS)
      |=> regRdData == {6'h00, $past(perButtonTouch)};
  endproperty
  a_touchRead: assert property (p_touchRead) else $error("touch state wrong");

  property p_unlock;
    @(posedge clk_sys) disable iff (rst)
      s_unlockKey ##1 !lockWrite |=> !addressLockState;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock key not honoured");

  property p_lockBit;
    @(posedge clk_sys) disable iff (rst)
      lockHit |=> addressLockState;
  endproperty
  a_lockBit: assert property (p_lockBit) else $error("lock key not honoured");
endmodule
`default_nettype wire

//--- verification/tsr_host_model.sv
// Host model: byte writes, byte reads and key sequences on the register port.
// Assumes the device samples strobes on rising edges of clk_sys.
`timescale 1ns/1ps
`default_nettype none
module tsr_host_model (
  input wire logic clk_sys,
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid
);
  initial begin
    {regWrite, regRead, regAddr, regWrData} = 18'h00000;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    {regWrite, regAddr, regWrData} = {1'b1, a, d};
    @(negedge clk_sys);
    // Released lines flip so stale values never pass for valid ones
    {regWrite, regAddr, regWrData} = {1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    {regRead, regAddr} = {1'b1, a};
    @(negedge clk_sys);
    d = regRdValid ? regRdData : 8'hXX;
    {regRead, regAddr} = {1'b0, ~a};
  endtask
  // Three key bytes to the lock register, first byte in the top bits
  task automatic key(input logic [23:0] k);
    for (int i = 2; i >= 0; i--) begin
      wr(8'h79, k[i*8+:8]);
    end
    // Lock state and applied address move one edge after the last key byte
    @(negedge clk_sys);
  endtask
endmodule
`default_nettype wire

//--- verification/tb_touch_scan_readout_regs.sv
// Self-checking bench for the touch scan readout register block.
// Assumes the host model drives the register port on falling edges.
`timescale 1ns/1ps
`default_nettype none
module tb_touch_scan_readout_regs;
  logic clk_sys, rst, regWrite, regRead, regRdValid, pullupDisable, readEnable, lockSt;
  logic [7:0] regAddr, regWrData, regRdData, d, v, cur;
  logic [1:0] inputEnable, perButtonTouch, mask, sel;
  logic [31:0] bl, dl, rw;
  logic [6:0] slaveAddr;
  int errors, n_checks, cyc;
  touch_scan_readout_regs DUT (.clk_sys(clk_sys), .rst(rst), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid), .inputEnable(inputEnable), .baselineValue(bl), .deltaValue(dl),
    .rawValue(rw), .perButtonTouch(perButtonTouch), .activeSlaveAddress(slaveAddr),
    .pullupDisable(pullupDisable), .buttonOnehotMask(mask), .readEnable(readEnable),
    .addressLockState(lockSt));
  tsr_host_model h (.clk_sys(clk_sys), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      errors++;
      test_done();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic test_done();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  function automatic logic [7:0] expRd(input logic [7:0] a, input logic [1:0] m, input logic e);
    logic [31:0] s;
    logic [15:0] w;
    s = a < 8'h84 ? bl : a < 8'h86 ? dl : rw;
    w = m[1] ? s[31:16] : s[15:0];
    if (a == 8'h88)
      return {6'h00, perButtonTouch};
    return e ? (a[0] ? w[7:0] : w[15:8]) : 8'h00;
  endfunction
  initial begin
    {rst, inputEnable, perButtonTouch, bl, dl, rw} = {1'b1, 4'hC, 96'h0};
    void'($urandom(32'hEFA8));
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    chk({lockSt, pullupDisable, readEnable, mask}, 8'h10);
    h.rd(8'h7C, d);
    chk(d, 8'h00);
    $display("test reset done");
    h.wr(8'h7C, 8'hA5);
    h.key(24'h965AC3);
    chk({pullupDisable, slaveAddr}, 8'h00);
    h.key(24'h3CA500);
    chk({7'h00, lockSt}, 8'h01);
    cur = 8'h00;
    for (int i = 0; i < 3; i++) begin
      v = $urandom;
      v[7] = i[0];
      h.key(24'h3CA569);
      chk({7'h00, lockSt}, 8'h00);
      h.wr(8'h7C, v);
      chk({pullupDisable, slaveAddr}, cur);
      h.rd(8'h7C, d);
      chk(d, v);
      h.key(24'h965AC3);
      cur = v;
      chk({pullupDisable, slaveAddr}, cur);
      chk({7'h00, lockSt}, 8'h01);
      h.rd(8'h79, d);
      chk(d, 8'h01);
    end
    $display("test address done");
    sel = 2'b00;
    for (int i = 0; i < 8; i++) begin
      inputEnable = i[2] ? 2'b01 : 2'b11;
      v = {i[0], 5'h00, i[1:0]};
      h.wr(8'h81, v);
      if ($onehot(v[1:0]) && (v[1:0] & inputEnable) == v[1:0])
        sel = v[1:0];
      chk({readEnable, mask}, {v[7], sel});
      h.rd(8'h81, d);
      chk(d, {v[7], 5'h00, sel});
    end
    $display("test select done");
    inputEnable = 2'b11;
    for (int i = 0; i < 6; i++) begin
      v = {i < 4, 5'h00, i[0] ? 2'b10 : 2'b01};
      h.wr(8'h81, v);
      @(negedge clk_sys);
      {bl, dl, rw, perButtonTouch} = {$urandom, $urandom, $urandom, 2'($urandom)};
      for (int a = 8'h82; a < 8'h89; a++) begin
        h.rd(8'(a), d);
        chk(d, expRd(8'(a), v[1:0], v[7]));
      end
    end
    h.rd(8'h90, d);
    chk(d, 8'h00);
    $display("test readout done");
    test_done();
  end
endmodule
`default_nettype wire
